// *** logic/pac_param_access.sv ***
// Parameter access command interpreter: frame receive, parameter stores, reply
// What this block does
// - Instruction 6 fetches the addressed axis parameter by type into the accumulator path
// - Axis read in direct mode answers status 100 with the value read
// - Instruction 7 copies the working axis parameter to EEPROM; value ignored
// - Instruction 8 reloads the axis parameter from EEPROM; value ignored
// - After reset, all axis parameters load from EEPROM before commands run
// - Instruction 9 writes the value into the global parameter of bank 0, 2 or 3
// - Bank 0 is settings, bank 2 user variables, bank 3 interrupt setup
// - Writing a bank 0 setting also commits it to EEPROM
// - Instruction 10 reads any global parameter into the accumulator path
// - Global read in direct mode answers status 100 with the value read
// - Instruction 11 stores a bank 2 user variable into EEPROM
// - Internal reads load the accumulator only in standalone mode; direct mode and link frames never do
// - Axis writes change only the working copy, not EEPROM
`timescale 1ns/1ps
module pac_param_access #(
    parameter int N_AXES    = 1,
    parameter int N_PARAMS  = 256
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Byte link from the host
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    // Mode and internal command request
    input  wire logic        standalone,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_op,
    input  wire logic [7:0]  cmd_type,
    input  wire logic [7:0]  cmd_bank,
    input  wire logic [31:0] cmd_value,
    // Handshake and reply to the host
    output logic             ready,
    output logic             reply_valid,
    output logic [7:0]       reply_host,
    output logic [7:0]       reply_target,
    output logic [7:0]       reply_status,
    output logic [7:0]       reply_op,
    output logic [31:0]      reply_value,
    // Accumulator and drop indication
    output logic [31:0]      accu,
    output logic             frame_dropped
);
    localparam int AW = $clog2(N_PARAMS);
    localparam int XW = (N_AXES > 1) ? $clog2(N_AXES) : 1;

    // Elaboration check: index widths and arrays serve at most 256 entries
    if (N_PARAMS < 2 || N_PARAMS > 256 || N_AXES < 1 || N_AXES > 256) begin : g_size_check
        $error("pac_param_access: unsupported parameter sizes");
    end

    // Working copies (SRAM) of each parameter group; non-volatile copies of axis, settings and user groups only
    logic [31:0] axis_work  [N_AXES][N_PARAMS];
    logic [31:0] axis_nv    [N_AXES][N_PARAMS];
    logic [31:0] glob_set   [N_PARAMS];
    logic [31:0] glob_set_nv[N_PARAMS];
    logic [31:0] glob_user  [N_PARAMS];
    logic [31:0] glob_user_nv[N_PARAMS];
    logic [31:0] glob_irq   [N_PARAMS];

    // Sequencer state and frame assembly
    pac_pkg::pac_state_t state;
    logic [7:0]  frame [pac_pkg::FRAME_BYTES];
    logic [3:0]  rx_cnt;
    logic [7:0]  rx_sum;
    logic [AW:0] boot_idx;
    logic        frame_ok;
    logic        frame_from_link;
    // Fields of the command being executed
    logic [7:0]  op;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
    // Decode results for the reply
    logic [7:0]  status;
    logic [31:0] rvalue;
    logic [AW-1:0] pidx;
    logic [XW-1:0] aidx;
    logic          axis_ok;
    logic          glob_ok;

    // Index range checks shared by all opcodes
    function automatic logic idx_ok(input logic [7:0] v, input int limit);
        idx_ok = (32'(v) < limit);
    endfunction

    assign pidx    = ptype[AW-1:0];
    assign aidx    = bank[XW-1:0];
    assign axis_ok = idx_ok(ptype, N_PARAMS) && idx_ok(bank, N_AXES);
    assign glob_ok = idx_ok(ptype, N_PARAMS);

    // Frame byte store; no reset needed, bytes are read only after capture
    always_ff @(posedge clk) begin
        if (rx_valid && state != pac_pkg::PAC_BOOT) begin
            frame[rx_cnt] <= rx_byte;
        end
    end

    // Frame assembly from the byte stream, running checksum
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt        <= 4'h0;
            rx_sum        <= 8'h00;
            frame_ok      <= 1'b0;
            frame_dropped <= 1'b0;
        end else begin
            frame_ok      <= 1'b0;
            frame_dropped <= 1'b0;
            if (rx_valid && state != pac_pkg::PAC_BOOT) begin
                if (32'(rx_cnt) == pac_pkg::CHK_INDEX) begin
                    rx_cnt <= 4'h0;
                    rx_sum <= 8'h00;
                    // Checksum and address filter
                    if (rx_byte == rx_sum && frame[0] == pac_pkg::MODULE_ADDR_RST) begin
                        frame_ok <= 1'b1;
                    end else begin
                        frame_dropped <= 1'b1;
                    end
                end else begin
                    rx_cnt <= rx_cnt + 4'h1;
                    rx_sum <= rx_sum + rx_byte;
                end
            end
        end
    end

    // Sequencer: boot load, idle, execute, reply
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state           <= pac_pkg::PAC_BOOT;
            boot_idx        <= '0;
            ready           <= 1'b0;
            op              <= 8'h00;
            ptype           <= 8'h00;
            bank            <= 8'h00;
            value           <= 32'h0;
            frame_from_link <= 1'b0;
        end else begin
            case (state)
                pac_pkg::PAC_BOOT: begin
                    boot_idx <= boot_idx + 1'b1;
                    if (32'(boot_idx) == N_PARAMS - 1) begin
                        state <= pac_pkg::PAC_IDLE;
                        ready <= 1'b1;
                    end
                end
                pac_pkg::PAC_IDLE: begin
                    if (frame_ok) begin
                        op              <= frame[1];
                        ptype           <= frame[2];
                        bank            <= frame[3];
                        value           <= {frame[4], frame[5], frame[6], frame[7]};
                        frame_from_link <= 1'b1;
                        ready           <= 1'b0;
                        state           <= pac_pkg::PAC_EXEC;
                    end else if (cmd_valid) begin
                        op              <= cmd_op;
                        ptype           <= cmd_type;
                        bank            <= cmd_bank;
                        value           <= cmd_value;
                        frame_from_link <= 1'b0;
                        ready           <= 1'b0;
                        state           <= pac_pkg::PAC_EXEC;
                    end
                end
                pac_pkg::PAC_EXEC: begin
                    state <= pac_pkg::PAC_REPLY;
                end
                pac_pkg::PAC_REPLY: begin
                    ready <= 1'b1;
                    state <= pac_pkg::PAC_IDLE;
                end
                default: begin
                    state <= pac_pkg::PAC_IDLE;
                end
            endcase
        end
    end

    // Boot-time load of every axis parameter from its EEPROM copy
    always_ff @(posedge clk) begin
        if (state == pac_pkg::PAC_BOOT) begin
            for (int a = 0; a < N_AXES; a++) begin
                axis_work[a][boot_idx[AW-1:0]] <= axis_nv[a][boot_idx[AW-1:0]];
            end
        end else if (state == pac_pkg::PAC_EXEC && axis_ok) begin
            if (op == pac_pkg::OP_AXIS_WRITE) begin
                axis_work[aidx][pidx] <= value;
            end else if (op == pac_pkg::OP_AXIS_RESTORE) begin
                axis_work[aidx][pidx] <= axis_nv[aidx][pidx];
            end
        end
    end

    // Non-volatile axis copies change only on the store opcode
    always_ff @(posedge clk) begin
        if (state == pac_pkg::PAC_EXEC && axis_ok && op == pac_pkg::OP_AXIS_STORE) begin
            axis_nv[aidx][pidx] <= axis_work[aidx][pidx];
        end
    end

    // Global parameter banks
    always_ff @(posedge clk) begin
        if (state == pac_pkg::PAC_EXEC && glob_ok && op == pac_pkg::OP_GLOB_WRITE) begin
            case (bank)
                pac_pkg::BANK_SETTINGS: begin
                    glob_set[pidx]    <= value;
                    glob_set_nv[pidx] <= value;
                end
                pac_pkg::BANK_USER: begin
                    glob_user[pidx] <= value;
                end
                pac_pkg::BANK_IRQ: begin
                    glob_irq[pidx] <= value;
                end
                default: begin
                end
            endcase
        end
    end

    // User variables reach EEPROM only on the store opcode
    always_ff @(posedge clk) begin
        if (state == pac_pkg::PAC_EXEC && glob_ok && op == pac_pkg::OP_GLOB_STORE
            && bank == pac_pkg::BANK_USER) begin
            glob_user_nv[pidx] <= glob_user[pidx];
        end
    end

    // Status and value of the reply, worked out during execution
    always_comb begin
        status = pac_pkg::ST_OK;
        rvalue = 32'h0;
        case (op)
            pac_pkg::OP_AXIS_WRITE, pac_pkg::OP_AXIS_STORE, pac_pkg::OP_AXIS_RESTORE: begin
                if (!axis_ok) status = pac_pkg::ST_BAD_VALUE;
            end
            pac_pkg::OP_AXIS_READ: begin
                if (!axis_ok) status = pac_pkg::ST_BAD_VALUE;
                else rvalue = axis_work[aidx][pidx];
            end
            pac_pkg::OP_GLOB_WRITE: begin
                if (!glob_ok || !(bank == pac_pkg::BANK_SETTINGS ||
                    bank == pac_pkg::BANK_USER || bank == pac_pkg::BANK_IRQ)) begin
                    status = pac_pkg::ST_BAD_VALUE;
                end
            end
            pac_pkg::OP_GLOB_READ: begin
                if (!glob_ok) status = pac_pkg::ST_BAD_VALUE;
                else begin
                    case (bank)
                        pac_pkg::BANK_SETTINGS: rvalue = glob_set[pidx];
                        pac_pkg::BANK_USER:     rvalue = glob_user[pidx];
                        pac_pkg::BANK_IRQ:      rvalue = glob_irq[pidx];
                        default:                status = pac_pkg::ST_BAD_VALUE;
                    endcase
                end
            end
            pac_pkg::OP_GLOB_STORE: begin
                if (!glob_ok || bank != pac_pkg::BANK_USER) status = pac_pkg::ST_BAD_VALUE;
            end
            default: status = pac_pkg::ST_BAD_OPCODE;
        endcase
    end

    // Reply strobe: one cycle, in the cycle after execution
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
        end else begin
            reply_valid <= (state == pac_pkg::PAC_EXEC);
        end
    end

    // Reply fields, standing until the next reply
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_host   <= 8'h00;
            reply_target <= 8'h00;
            reply_status <= 8'h00;
            reply_op     <= 8'h00;
            reply_value  <= 32'h0;
        end else if (state == pac_pkg::PAC_EXEC) begin
            reply_host   <= pac_pkg::HOST_ADDR_RST;
            reply_target <= pac_pkg::MODULE_ADDR_RST;
            reply_status <= status;
            reply_op     <= op;
            reply_value  <= rvalue;
        end
    end

    // Accumulator: direct mode and link frames leave it alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accu <= pac_pkg::ACCU_RST;
        end else if (state == pac_pkg::PAC_EXEC && status == pac_pkg::ST_OK && standalone &&
                     !frame_from_link &&
                     (op == pac_pkg::OP_AXIS_READ || op == pac_pkg::OP_GLOB_READ)) begin
            accu <= rvalue;
        end
    end
endmodule

// *** logic/pac_pkg.sv ***
// Constants and types shared by the parameter access command interpreter
package pac_pkg;
    // Instruction codes
    localparam logic [7:0] OP_AXIS_WRITE   = 8'h05;
    localparam logic [7:0] OP_AXIS_READ    = 8'h06;
    localparam logic [7:0] OP_AXIS_STORE   = 8'h07;
    localparam logic [7:0] OP_AXIS_RESTORE = 8'h08;
    localparam logic [7:0] OP_GLOB_WRITE   = 8'h09;
    localparam logic [7:0] OP_GLOB_READ    = 8'h0a;
    localparam logic [7:0] OP_GLOB_STORE   = 8'h0b;
    // Banks
    localparam logic [7:0] BANK_SETTINGS   = 8'h00;
    localparam logic [7:0] BANK_USER       = 8'h02;
    localparam logic [7:0] BANK_IRQ        = 8'h03;
    // Reply status codes
    localparam logic [7:0] ST_OK           = 8'h64;
    localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] ST_BAD_OPCODE   = 8'h02;
    localparam logic [7:0] ST_BAD_VALUE    = 8'h04;
    // Frame layout
    localparam int FRAME_BYTES             = 9;
    localparam int CHK_INDEX               = 8;
    // Reset values
    localparam logic [7:0]  MODULE_ADDR_RST = 8'h01;
    localparam logic [7:0]  HOST_ADDR_RST   = 8'h02;
    localparam logic [31:0] ACCU_RST        = 32'h0000_0000;

    typedef enum logic [2:0] {
        PAC_BOOT,
        PAC_IDLE,
        PAC_EXEC,
        PAC_REPLY
    } pac_state_t;
endpackage

// *** verification/pac_host.sv ***
// Host model that sends command frames on the byte link
`timescale 1ns/1ps
module pac_host (
    input  wire logic  clk,
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    // Link idles with no byte offered
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end
    // One whole frame; a nonzero spoil breaks the checksum
    task automatic send(input logic [7:0] addr, op, typ, bank, input logic [31:0] value,
                        input logic [7:0] spoil);
        logic [7:0] b [9];
        b = '{addr, op, typ, bank, value[31:24], value[23:16], value[15:8], value[7:0], 8'h00};
        for (int i = 0; i < 8; i++)
            b[8] += b[i];
        b[8] ^= spoil;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte  <= b[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b[8]; // Idle lane shows no stale byte
    endtask
endmodule

// *** verification/pac_monitor.sv ***
// Port-level assertions for the parameter access interpreter
`timescale 1ns/1ps
module pac_monitor #(
    parameter int N_PARAMS = 256
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_byte,
    input wire logic        standalone,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_op,
    input wire logic [7:0]  cmd_type,
    input wire logic [7:0]  cmd_bank,
    input wire logic [31:0] cmd_value,
    input wire logic        ready,
    input wire logic        reply_valid,
    input wire logic [7:0]  reply_host,
    input wire logic [7:0]  reply_target,
    input wire logic [7:0]  reply_status,
    input wire logic [7:0]  reply_op,
    input wire logic [31:0] reply_value,
    input wire logic [31:0] accu,
    input wire logic        frame_dropped
);
    localparam int BOOT_MAX = N_PARAMS + 4;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Internal request taken while idle, away from a finishing frame
    sequence s_take;
        ready && cmd_valid && !rx_valid && !$past(rx_valid);
    endsequence
    sequence s_answer;
        ##2 reply_valid;
    endsequence
    // Successful read reply in standalone mode
    sequence s_local_read;
        reply_valid && standalone && reply_status == pac_pkg::ST_OK &&
        (reply_op == pac_pkg::OP_AXIS_READ || reply_op == pac_pkg::OP_GLOB_READ);
    endsequence
    AST_BOOT: assert property ($rose(rst_b) |-> !ready ##[1:BOOT_MAX] ready)
        else $error("ready late after boot load");
    AST_TAKE: assert property (s_take |-> s_answer ##0 reply_op == $past(cmd_op, 2))
        else $error("internal request not answered in time");
    AST_PULSE: assert property (reply_valid |=> !reply_valid && ready)
        else $error("reply pulse or ready return wrong");
    AST_BUSY: assert property (reply_valid |-> !ready)
        else $error("ready high during reply");
    AST_IDS: assert property (reply_valid |-> reply_host == pac_pkg::HOST_ADDR_RST &&
        reply_target == pac_pkg::MODULE_ADDR_RST)
        else $error("reply addresses wrong");
    AST_DROP: assert property (frame_dropped |=>
        (!frame_dropped && !reply_valid) ##1 !reply_valid)
        else $error("dropped frame answered");
    AST_HOLD: assert property ((!standalone) [*4] |-> $stable(accu))
        else $error("accumulator moved in direct mode");
    AST_LOAD: assert property (s_local_read |-> ##[0:2] accu == reply_value)
        else $error("accumulator missed read value");
endmodule

// *** verification/parameter_access_commands_test.sv ***
// Self-checking bench for the parameter access command interpreter
`timescale 1ns/1ps
module parameter_access_commands_test;
    typedef struct packed {
        logic [7:0]  op;
        logic [7:0]  typ;
        logic [7:0]  bank;
        logic [31:0] value;
        logic [7:0]  status;
        logic [31:0] exp;
    } pac_row_t;
    logic        clk, rst_b, rx_valid, standalone, cmd_valid, ready, reply_valid, frame_dropped;
    logic [7:0]  rx_byte, cmd_op, cmd_type, cmd_bank, reply_host, reply_target, reply_status;
    logic [7:0]  reply_op;
    logic [31:0] cmd_value, reply_value, accu;
    int          n_errors = 0;
    int          n_checks = 0;
    // Frame cases in order; later reads depend on earlier writes
    pac_row_t    rows [16] = '{
        '{pac_pkg::OP_AXIS_WRITE, 8'h03, 8'h00, 32'h12345678, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_AXIS_READ, 8'h03, 8'h00, 32'h0, pac_pkg::ST_OK, 32'h12345678},
        '{pac_pkg::OP_AXIS_STORE, 8'h03, 8'h00, 32'hdeadbeef, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_AXIS_WRITE, 8'h03, 8'h00, 32'h11, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_AXIS_RESTORE, 8'h03, 8'h00, 32'hcafe0000, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_AXIS_READ, 8'h03, 8'h00, 32'h0, pac_pkg::ST_OK, 32'h12345678},
        '{pac_pkg::OP_GLOB_WRITE, 8'h0a, 8'h02, 32'ha5a50001, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_GLOB_READ, 8'h0a, 8'h02, 32'h0, pac_pkg::ST_OK, 32'ha5a50001},
        '{pac_pkg::OP_GLOB_STORE, 8'h0a, 8'h02, 32'h0, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_GLOB_WRITE, 8'h07, 8'h00, 32'h55, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_GLOB_READ, 8'h07, 8'h00, 32'h0, pac_pkg::ST_OK, 32'h55},
        '{pac_pkg::OP_GLOB_WRITE, 8'h07, 8'h03, 32'h66, pac_pkg::ST_OK, 32'h0},
        '{pac_pkg::OP_GLOB_READ, 8'h07, 8'h03, 32'h0, pac_pkg::ST_OK, 32'h66},
        '{pac_pkg::OP_GLOB_WRITE, 8'h07, 8'h01, 32'h66, pac_pkg::ST_BAD_VALUE, 32'h0},
        '{pac_pkg::OP_GLOB_READ, 8'h2a, 8'h02, 32'h0, pac_pkg::ST_BAD_VALUE, 32'h0},
        '{8'h20, 8'h00, 8'h00, 32'h0, pac_pkg::ST_BAD_OPCODE, 32'h0}
    };
    pac_host host (.clk, .rx_valid, .rx_byte);
    pac_param_access #(.N_PARAMS(16)) uut (
        .clk, .rst_b, .rx_valid, .rx_byte, .standalone, .cmd_valid, .cmd_op, .cmd_type,
        .cmd_bank, .cmd_value, .ready, .reply_valid, .reply_host, .reply_target,
        .reply_status, .reply_op, .reply_value, .accu, .frame_dropped
    );
    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic compare(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Reset, then wait for the boot load to finish
    task automatic reset_dut(input int cycles);
        rst_b <= 1'b0;
        repeat (cycles) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        compare({31'h0, ready}, 32'h1);
    endtask
    // Frame; drop flag stands in the cycle after the checksum byte, reply two cycles later
    task automatic run_frame(input logic [7:0] addr, op, typ, bank, input logic [31:0] value,
                             input logic [7:0] spoil, input logic ok);
        host.send(addr, op, typ, bank, value, spoil);
        #1;
        compare({31'h0, frame_dropped}, {31'h0, !ok});
        repeat (2) @(posedge clk);
        #1;
        compare({31'h0, reply_valid}, {31'h0, ok});
        @(posedge clk);
    endtask
    // Internal command pulse, then wait past the answer
    task automatic issue(input logic [7:0] op, typ, bank);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_type  <= typ;
        cmd_bank  <= bank;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Watchdog
    initial begin
        #40000;
        n_errors++;
        print_verdict();
    end
    // Table cases, then refused frames, standalone reads and a second reset
    initial begin
        rst_b = 1'b0;
        standalone = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_type = 8'h00;
        cmd_bank = 8'h00;
        cmd_value = 32'h0;
        reset_dut(12);
        foreach (rows[i]) begin
            run_frame(8'h01, rows[i].op, rows[i].typ, rows[i].bank, rows[i].value, 8'h00,
                      1'b1);
            compare({24'h0, reply_status}, {24'h0, rows[i].status});
            compare({24'h0, reply_op}, {24'h0, rows[i].op});
            compare({16'h0, reply_host, reply_target},
                    {16'h0, pac_pkg::HOST_ADDR_RST, pac_pkg::MODULE_ADDR_RST});
            if (rows[i].op == pac_pkg::OP_AXIS_READ || rows[i].op == pac_pkg::OP_GLOB_READ)
                compare(reply_value, rows[i].exp);
        end
        compare(accu, 32'h0);
        run_frame(8'h01, pac_pkg::OP_AXIS_WRITE, 8'h03, 8'h00, 32'h77, 8'h01, 1'b0);
        run_frame(8'h05, pac_pkg::OP_AXIS_WRITE, 8'h03, 8'h00, 32'h77, 8'h00, 1'b0);
        run_frame(8'h01, pac_pkg::OP_AXIS_READ, 8'h03, 8'h00, 32'h0, 8'h00, 1'b1);
        compare(reply_value, 32'h12345678);
        @(posedge clk);
        standalone <= 1'b1;
        issue(pac_pkg::OP_GLOB_READ, 8'h0a, 8'h02);
        compare(accu, 32'ha5a50001);
        issue(pac_pkg::OP_AXIS_READ, 8'h03, 8'h00);
        compare(accu, 32'h12345678);
        @(posedge clk);
        standalone <= 1'b0;
        reset_dut(2);
        run_frame(8'h01, pac_pkg::OP_AXIS_READ, 8'h03, 8'h00, 32'h0, 8'h00, 1'b1);
        compare(reply_value, 32'h12345678);
        print_verdict();
    end
endmodule
bind pac_param_access pac_monitor #(.N_PARAMS(N_PARAMS)) mon (
    .clk, .rst_b, .rx_valid, .rx_byte, .standalone, .cmd_valid, .cmd_op, .cmd_type,
    .cmd_bank, .cmd_value, .ready, .reply_valid, .reply_host, .reply_target,
    .reply_status, .reply_op, .reply_value, .accu, .frame_dropped
);
